//--- hdl/rcbl_pkg.sv
// constants for the reset-time configuration byte loader
package rcbl_pkg;
   // external addresses of the two used configuration bytes
   localparam logic [23:0] RCBL_CFG0_ADDR = 24'hFFFFF8;
   localparam logic [23:0] RCBL_CFG1_ADDR = 24'hFFFFF9;
   // byte zero fields
   localparam int RCBL_B0_RSVD   = 7;
   localparam int RCBL_B0_WSA_HI = 6;
   localparam int RCBL_B0_WSA_LO = 5;
   localparam int RCBL_B0_LATCH  = 4;
   localparam int RCBL_B0_RNG_HI = 3;
   localparam int RCBL_B0_RNG_LO = 2;
   localparam int RCBL_B0_PAGE_N = 1;
   localparam int RCBL_B0_OPCODE = 0;
   // byte one fields
   localparam int RCBL_B1_IRQ    = 4;
   localparam int RCBL_B1_WSB_HI = 2;
   localparam int RCBL_B1_WSB_LO = 1;
   localparam int RCBL_B1_MAP_N  = 0;
   // address range select encodings
   localparam logic [1:0] RCBL_RNG_256K = 2'h0;
   localparam logic [1:0] RCBL_RNG_128K = 2'h1;
   localparam logic [1:0] RCBL_RNG_64K  = 2'h2;
   localparam logic [1:0] RCBL_RNG_SPLIT = 2'h3;
   localparam logic [4:0] RCBL_ABITS_18 = 5'h12;
   localparam logic [4:0] RCBL_ABITS_17 = 5'h11;
   localparam logic [4:0] RCBL_ABITS_16 = 5'h10;
   // strobe width in oscillator periods, pushed interrupt bytes
   localparam logic [1:0] RCBL_LATCH_LONG  = 2'h3;
   localparam logic [1:0] RCBL_LATCH_SHORT = 2'h1;
   localparam logic [2:0] RCBL_PUSH_SMALL  = 3'h2;
   localparam logic [2:0] RCBL_PUSH_LARGE  = 3'h4;
   // pin synchroniser settle time before the source is chosen
   localparam logic [1:0] RCBL_SETTLE_CYCLES = 2'h2;
   // apb register map
   localparam logic [11:0] RCBL_OFS_BYTE0  = 12'h000;
   localparam logic [11:0] RCBL_OFS_BYTE1  = 12'h004;
   localparam logic [11:0] RCBL_OFS_STATUS = 12'h008;
   localparam logic [11:0] RCBL_OFS_CTRL   = 12'h00C;
   localparam logic        RCBL_CTRL_RESET = 1'b0;
   localparam int RCBL_ST_VALID = 0;
   localparam int RCBL_ST_EXT   = 1;
   localparam int RCBL_ST_PAGE  = 2;
   localparam int RCBL_ST_RSVOK = 3;
endpackage

//--- hdl/rcbl_loader.sv
// reset-time configuration byte loader with apb readback
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1: settings for memory bus, opcodes, irq frame, code map come from two bytes.
// RL2: pin low: read bytes from the top eight external locations.
// RL3: byte zero from the lowest reserved address, byte one from the next.
// RL4: pin high: take both bytes from on-chip memory, no external reads.
// RL5: programmer writes byte zero bit 7 as one.
// RL6: byte zero bits 6:5 give general wait states, 00 three to 11 none.
// RL7: byte zero bit 4 clear gives three-period latch strobe, set gives one.
// RL8: byte zero bits 3:2 select address width and strobe usage.
// RL9: 00 256 KB, 01 128 KB, 10 64 KB, 11 split code and data.
// RL10: byte zero bit 1 clear selects page mode, set non-page mode.
// RL11: byte zero bit 0 clear binary opcodes, set source opcodes.
// RL12: byte zero fetched twice; port 2 bit 1 low on first picks page mode.
// RL13: byte one bits 2:1 give region 01 wait states, same encoding.
// RL14: byte one irq bit clear pushes two bytes, set pushes four.
// RL15: byte one map bit clear maps upper 16 KB code into data region 00.
// RL16: decoded settings latch once fetching ends and hold until reset.
module rcbl_loader
   import rcbl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        external_code_select_pin,
   input  wire logic        port2_bit1_pin,
   input  wire logic [7:0]  onchip_cfg0,
   input  wire logic [7:0]  onchip_cfg1,
   output logic             mem_rd_req,
   output logic [23:0]      mem_rd_addr,
   output logic             mem_page_mode,
   input  wire logic        mem_rd_ack,
   input  wire logic [7:0]  mem_rd_data,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cfg_valid,
   output logic [1:0]       wait_count_general,
   output logic [1:0]       wait_count_region1,
   output logic [1:0]       latch_strobe_periods,
   output logic [4:0]       addr_bus_bits,
   output logic             addr17_on_port1,
   output logic             addr16_on_port3,
   output logic             split_code_data,
   output logic             page_mode,
   output logic             source_mode,
   output logic [2:0]       irq_push_bytes,
   output logic             code_to_data_map_en
);

   typedef enum logic [2:0] {
      RCBL_SETTLE, RCBL_PICK, RCBL_FETCH0A, RCBL_FETCH0B, RCBL_FETCH1, RCBL_APPLY,
      RCBL_HOLD
   } rcbl_state_t;

   rcbl_state_t state_r;
   rcbl_state_t state_nxt;
   logic [1:0]  ea_sync_r;
   logic [1:0]  p21_sync_r;
   logic [1:0]  settle_r;
   logic [7:0]  cfg0_r;
   logic [7:0]  cfg1_r;
   logic        ext_src_r;
   logic        fetch_page_r;
   logic        check_en_r;
   logic [31:0] rdata_r;
   logic [1:0]  fetch_cnt_r;

   wire         ea_level = ea_sync_r[1];
   wire         p21_level = p21_sync_r[1];
   wire         fetching = (state_r == RCBL_FETCH0A) || (state_r == RCBL_FETCH0B) ||
                           (state_r == RCBL_FETCH1);
   wire         got_byte = fetching && mem_rd_ack;
   wire         apply = (state_r == RCBL_APPLY);

   // both pins come from outside, two flops before any use
   always_ff @(posedge clk) begin
      if (rst) begin
         ea_sync_r  <= 2'h0;
         p21_sync_r <= 2'h0;
      end else begin
         ea_sync_r  <= {ea_sync_r[0], external_code_select_pin};
         p21_sync_r <= {p21_sync_r[0], port2_bit1_pin};
      end
   end

   // hold off the source choice until the synchronised pin is valid
   always_ff @(posedge clk) begin
      if (rst)
         settle_r <= 2'h0;
      else if (state_r == RCBL_SETTLE)
         settle_r <= settle_r + 2'h1;
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         RCBL_SETTLE:  if (settle_r == RCBL_SETTLE_CYCLES) state_nxt = RCBL_PICK;
         RCBL_PICK:    state_nxt = ea_level ? RCBL_APPLY : RCBL_FETCH0A; // RL2 RL4
         RCBL_FETCH0A: if (mem_rd_ack) state_nxt = RCBL_FETCH0B; // RL12
         RCBL_FETCH0B: if (mem_rd_ack) state_nxt = RCBL_FETCH1;
         RCBL_FETCH1:  if (mem_rd_ack) state_nxt = RCBL_APPLY;
         RCBL_APPLY:   state_nxt = RCBL_HOLD;
         RCBL_HOLD:    state_nxt = RCBL_HOLD; // RL16
         default:      state_nxt = RCBL_SETTLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst)
         state_r <= RCBL_SETTLE;
      else
         state_r <= state_nxt;
   end

   // external fetch port: request held until the memory acknowledges
   assign mem_rd_req  = fetching;
   assign mem_rd_addr = (state_r == RCBL_FETCH1) ? RCBL_CFG1_ADDR : RCBL_CFG0_ADDR; // RL2 RL3
   assign mem_page_mode = fetch_page_r;

   // first fetch runs non-page; port 2 bit 1 low switches later ones to page
   always_ff @(posedge clk) begin
      if (rst)
         fetch_page_r <= 1'b0;
      else if (state_r == RCBL_FETCH0A && mem_rd_ack)
         fetch_page_r <= ~p21_level; // RL12
   end

   // raw bytes; the second byte-zero fetch overwrites the first
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg0_r    <= 8'h00;
         cfg1_r    <= 8'h00;
         ext_src_r <= 1'b0;
      end else if (state_r == RCBL_PICK && ea_level) begin
         cfg0_r    <= onchip_cfg0; // RL4
         cfg1_r    <= onchip_cfg1;
      end else if (got_byte) begin
         ext_src_r <= 1'b1;
         if (state_r == RCBL_FETCH1)
            cfg1_r <= mem_rd_data; // RL3
         else
            cfg0_r <= mem_rd_data; // RL3
      end
   end

   wire [1:0] rng_sel = {cfg0_r[RCBL_B0_RNG_HI], cfg0_r[RCBL_B0_RNG_LO]};
   wire [1:0] wsa_bits = {cfg0_r[RCBL_B0_WSA_HI], cfg0_r[RCBL_B0_WSA_LO]};
   wire [1:0] wsb_bits = {cfg1_r[RCBL_B1_WSB_HI], cfg1_r[RCBL_B1_WSB_LO]};
   // active-low encodings: 00 gives three waits, 11 none
   wire [1:0] wsa_count = ~wsa_bits; // RL6
   wire [1:0] wsb_count = ~wsb_bits; // RL13
   wire [4:0] abits_dec = (rng_sel == RCBL_RNG_256K) ? RCBL_ABITS_18 :
                          (rng_sel == RCBL_RNG_128K) ? RCBL_ABITS_17 : RCBL_ABITS_16; // RL8 RL9

   // decoded settings written once, then frozen until reset
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_valid            <= 1'b0;
         wait_count_general   <= 2'h3;
         wait_count_region1   <= 2'h3;
         latch_strobe_periods <= RCBL_LATCH_LONG;
         addr_bus_bits        <= RCBL_ABITS_16;
         addr17_on_port1      <= 1'b0;
         addr16_on_port3      <= 1'b0;
         split_code_data      <= 1'b0;
         page_mode            <= 1'b0;
         source_mode          <= 1'b0;
         irq_push_bytes       <= RCBL_PUSH_SMALL;
         code_to_data_map_en  <= 1'b0;
      end else if (apply) begin // RL1 RL16
         cfg_valid            <= 1'b1;
         wait_count_general   <= wsa_count; // RL6
         wait_count_region1   <= wsb_count; // RL13
         latch_strobe_periods <= cfg0_r[RCBL_B0_LATCH] ? RCBL_LATCH_SHORT
                                                        : RCBL_LATCH_LONG; // RL7
         addr_bus_bits        <= abits_dec; // RL8
         addr17_on_port1      <= (rng_sel == RCBL_RNG_256K); // RL9
         addr16_on_port3      <= (rng_sel == RCBL_RNG_256K) ||
                                 (rng_sel == RCBL_RNG_128K); // RL9
         split_code_data      <= (rng_sel == RCBL_RNG_SPLIT); // RL9
         page_mode            <= ~cfg0_r[RCBL_B0_PAGE_N]; // RL10
         source_mode          <= cfg0_r[RCBL_B0_OPCODE]; // RL11
         irq_push_bytes       <= cfg1_r[RCBL_B1_IRQ] ? RCBL_PUSH_LARGE
                                                     : RCBL_PUSH_SMALL; // RL14
         code_to_data_map_en  <= ~cfg1_r[RCBL_B1_MAP_N]; // RL15
      end
   end

   // apb slave: zero wait states, read data captured in the setup cycle
   wire       setup_ph  = psel && !penable;
   wire       access_ph = psel && penable;
   wire       hit_byte0 = (paddr == RCBL_OFS_BYTE0);
   wire       hit_byte1 = (paddr == RCBL_OFS_BYTE1);
   wire       hit_stat  = (paddr == RCBL_OFS_STATUS);
   wire       hit_ctrl  = (paddr == RCBL_OFS_CTRL);
   wire       mapped    = hit_byte0 || hit_byte1 || hit_stat || hit_ctrl;
   wire       ctrl_wr   = access_ph && pwrite && hit_ctrl && pstrb[0];
   // reserved bit of byte zero is expected set; checking is optional
   wire       rsv_ok    = cfg0_r[RCBL_B0_RSVD] || !check_en_r; // RL5
   wire [3:0] status_w  = {rsv_ok, fetch_page_r, ext_src_r, cfg_valid};
   wire [31:0] rd_mux   = hit_byte0 ? {24'h000000, cfg0_r} :
                          hit_byte1 ? {24'h000000, cfg1_r} :
                          hit_stat  ? {28'h0000000, status_w} :
                          hit_ctrl  ? {31'h0000000, check_en_r} : 32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = access_ph && !mapped;
   assign prdata  = rdata_r;

   always_ff @(posedge clk) begin
      if (rst)
         rdata_r <= 32'h00000000;
      else if (setup_ph && !pwrite)
         rdata_r <= rd_mux;
   end

   always_ff @(posedge clk) begin
      if (rst)
         check_en_r <= RCBL_CTRL_RESET;
      else if (ctrl_wr)
         check_en_r <= pwdata[0];
   end

   // fetch tally for the checks below, not used by the datapath
   always_ff @(posedge clk) begin
      if (rst)
         fetch_cnt_r <= 2'h0;
      else if (got_byte)
         fetch_cnt_r <= fetch_cnt_r + 2'h1;
   end

   // ---------------- assertions ----------------
   default clocking rcbl_cb @(posedge clk); endclocking
   default disable iff (rst);

   property fetch_order_p;
      (state_r == RCBL_FETCH0B && mem_rd_ack) |=>
         mem_rd_req && mem_rd_addr == RCBL_CFG1_ADDR;
   endproperty
   fetch_order_a: assert property (fetch_order_p) // RL3
      else $error("byte one not fetched after byte zero");

   first_addr_a: assert property ( // RL2
      $rose(mem_rd_req) |-> mem_rd_addr == RCBL_CFG0_ADDR && !mem_page_mode)
      else $error("fetch sequence did not start at byte zero");

   onchip_path_a: assert property ( // RL4
      (state_r == RCBL_PICK && ea_level) |-> ##1 apply ##1 cfg_valid && !mem_rd_req
         ##0 source_mode == onchip_cfg0[0] ##0 !ext_src_r)
      else $error("on-chip configuration path misbehaved");

   page_pick_a: assert property ( // RL12
      (state_r == RCBL_FETCH0A && mem_rd_ack) |=> mem_page_mode == !$past(p21_level))
      else $error("fetch mode not chosen from port 2 bit 1");

   general_wait_a: assert property ( // RL6
      $rose(cfg_valid) |-> wait_count_general == 2'(3 - $past(wsa_bits)))
      else $error("general wait count decode wrong");

   region_wait_a: assert property ( // RL13
      $rose(cfg_valid) |-> wait_count_region1 == 2'(3 - $past(wsb_bits)))
      else $error("region 01 wait count decode wrong");

   latch_width_a: assert property ( // RL7
      $rose(cfg_valid) |-> latch_strobe_periods ==
         ($past(cfg0_r[RCBL_B0_LATCH]) ? 2'h1 : 2'h3))
      else $error("latch strobe width decode wrong");

   addr_width_a: assert property ( // RL8 RL9
      $rose(cfg_valid) |-> (addr_bus_bits == 5'h12) == addr17_on_port1
         ##0 (addr_bus_bits != 5'h10) == addr16_on_port3
         ##0 !(split_code_data && addr_bus_bits != 5'h10))
      else $error("address width and strobe usage disagree");

   modes_a: assert property ( // RL10 RL11
      $rose(cfg_valid) |-> page_mode != $past(cfg0_r[RCBL_B0_PAGE_N])
         ##0 source_mode == $past(cfg0_r[RCBL_B0_OPCODE]))
      else $error("page or opcode mode decode wrong");

   irq_map_a: assert property ( // RL14 RL15
      $rose(cfg_valid) |-> irq_push_bytes == ($past(cfg1_r[RCBL_B1_IRQ]) ? 3'h4 : 3'h2)
         ##0 code_to_data_map_en != $past(cfg1_r[RCBL_B1_MAP_N]))
      else $error("irq frame or code map decode wrong");

   settings_hold_a: assert property ( // RL16 RL1
      cfg_valid |=> cfg_valid && $stable(wait_count_general) && $stable(addr_bus_bits)
         && $stable(irq_push_bytes) && $stable(page_mode))
      else $error("settings changed after being applied");

   apb_err_a: assert property ( // RL1
      (access_ph && !mapped) |-> pslverr && pready && (pwrite || prdata == 32'h00000000))
      else $error("unmapped access not flagged");

   // settle counter parks at three, so the pick always sees a flushed pin
   pick_settled_a: assert property ((state_r == RCBL_PICK) |-> settle_r == 2'h3) // RL2 RL4
      else $error("source picked before the pin synchroniser settled");

   ext_start_a: assert property ( // RL2
      (state_r == RCBL_PICK && !ea_level) |=> mem_rd_req && mem_rd_addr == RCBL_CFG0_ADDR)
      else $error("external fetch did not start after the pick");

   refetch_a: assert property ( // RL12
      (state_r == RCBL_FETCH0A && mem_rd_ack) |=> mem_rd_req && mem_rd_addr == RCBL_CFG0_ADDR)
      else $error("byte zero not fetched a second time");

   req_hold_a: assert property ( // RL3
      (mem_rd_req && !mem_rd_ack) |=> mem_rd_req && $stable(mem_rd_addr))
      else $error("fetch request dropped before its acknowledge");

   fetch_count_a: assert property ( // RL3 RL12
      $rose(cfg_valid) |-> fetch_cnt_r == (ext_src_r ? 2'h3 : 2'h0))
      else $error("wrong number of configuration fetches");

   settings_rest_a: assert property ( // RL16
      cfg_valid |=> $stable(wait_count_region1) && $stable(latch_strobe_periods)
         && $stable(source_mode) && $stable(code_to_data_map_en) && $stable(split_code_data))
      else $error("late change in the remaining settings");

   byte_read_a: assert property ( // RL1
      (setup_ph && !pwrite && hit_byte0) |=> prdata == {24'h000000, $past(cfg0_r)})
      else $error("byte zero readback wrong");

   status_read_a: assert property ( // RL1
      (setup_ph && !pwrite && hit_stat) |=> prdata[31:4] == 28'h0000000
         && prdata[0] == $past(cfg_valid) && prdata[1] == $past(ext_src_r)
         && prdata[2] == $past(fetch_page_r))
      else $error("status readback wrong");

   ctrl_write_a: assert property ( // RL5
      ctrl_wr |=> check_en_r == $past(pwdata[0]))
      else $error("check enable not written");

   ctrl_strobe_a: assert property ( // RL5
      (access_ph && pwrite && hit_ctrl && !pstrb[0]) |=> $stable(check_en_r))
      else $error("check enable written without its byte strobe");

   ext_boot_c: cover property ($rose(cfg_valid) && ext_src_r && mem_page_mode);
   page_off_c: cover property ($rose(cfg_valid) && ext_src_r && !mem_page_mode);
   onchip_boot_c: cover property ($rose(cfg_valid) && !ext_src_r);
   split_mode_c: cover property ($rose(cfg_valid) && split_code_data);
   stat_read_c: cover property (access_ph && !pwrite && hit_stat && cfg_valid);

endmodule
`default_nettype wire

//--- tb/rcbl_ext_mem.sv
// external memory model holding the configuration array
`timescale 1ns/100ps
`default_nettype none
module rcbl_ext_mem
   import rcbl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mem_rd_req,
   input  wire logic [23:0] mem_rd_addr,
   input  wire logic [3:0]  ack_delay,
   input  wire logic [7:0]  cfg0,
   input  wire logic [7:0]  cfg1,
   output logic             mem_rd_ack,
   output logic [7:0]       mem_rd_data
);
   logic [3:0] wait_r;
   // valid bytes only at the two used locations
   wire logic [7:0] rom_byte = (mem_rd_addr == RCBL_CFG0_ADDR) ? cfg0 :
                               (mem_rd_addr == RCBL_CFG1_ADDR) ? cfg1 : 8'hA5;
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_rd_ack  <= 1'b0;
         wait_r      <= 4'h0;
         mem_rd_data <= 8'h00;
      end else begin
         mem_rd_ack  <= 1'b0;
         // undriven bus: toggles so stale data never looks valid
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req && !mem_rd_ack) begin
            if (wait_r == ack_delay) begin
               mem_rd_ack  <= 1'b1;
               mem_rd_data <= rom_byte;
               wait_r      <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_reset_config_byte_loader.sv
// self-checking bench for the reset-time configuration loader
`timescale 1ns/100ps
`default_nettype none
module tb_reset_config_byte_loader;
   import rcbl_pkg::*;
   logic        clk, rst, external_code_select_pin, port2_bit1_pin, mem_rd_req, mem_rd_ack;
   logic        mem_page_mode, psel, penable, pwrite, pready, pslverr, cfg_valid;
   logic        addr17_on_port1, addr16_on_port3, split_code_data, page_mode;
   logic        source_mode, code_to_data_map_en;
   logic [7:0]  onchip_cfg0, onchip_cfg1, mem_rd_data, mem0, mem1;
   logic [23:0] mem_rd_addr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, ack_delay;
   logic [1:0]  wait_count_general, wait_count_region1, latch_strobe_periods;
   logic [4:0]  addr_bus_bits;
   logic [2:0]  irq_push_bytes;
   logic [23:0] seen_addr[$];
   logic        seen_page[$];
   int          req_cycles, mismatches, tests_run;
   wire logic [19:0] dec = {wait_count_general, wait_count_region1, latch_strobe_periods,
      addr_bus_bits, addr17_on_port1, addr16_on_port3, split_code_data, page_mode,
      source_mode, irq_push_bytes, code_to_data_map_en};

   rcbl_loader dut (.clk, .rst, .external_code_select_pin, .port2_bit1_pin, .onchip_cfg0,
      .onchip_cfg1, .mem_rd_req, .mem_rd_addr, .mem_page_mode, .mem_rd_ack, .mem_rd_data,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .cfg_valid, .wait_count_general, .wait_count_region1, .latch_strobe_periods,
      .addr_bus_bits, .addr17_on_port1, .addr16_on_port3, .split_code_data, .page_mode,
      .source_mode, .irq_push_bytes, .code_to_data_map_en);
   rcbl_ext_mem far_mem (.clk, .rst, .mem_rd_req, .mem_rd_addr, .ack_delay, .cfg0(mem0),
      .cfg1(mem1), .mem_rd_ack, .mem_rd_data);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (!rst && mem_rd_req) req_cycles++;
      if (!rst && mem_rd_req && mem_rd_ack) begin
         seen_addr.push_back(mem_rd_addr);
         seen_page.push_back(mem_page_mode);
      end
   end

   function automatic logic [19:0] expect_dec(input logic [7:0] b0, input logic [7:0] b1);
      logic [1:0] r;
      r = b0[3:2];
      return {2'h3 - b0[6:5], 2'h3 - b1[2:1], b0[4] ? RCBL_LATCH_SHORT : RCBL_LATCH_LONG,
         (r == 2'h0) ? RCBL_ABITS_18 : (r == 2'h1) ? RCBL_ABITS_17 : RCBL_ABITS_16,
         r == 2'h0, r <= 2'h1, r == 2'h3, ~b0[1], b0[0],
         b1[4] ? RCBL_PUSH_LARGE : RCBL_PUSH_SMALL, ~b1[0]};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the unused source gets inverted bytes so a wrong pick shows
   task automatic boot(input logic ext, input logic p21, input logic [7:0] b0, b1);
      int n;
      rst <= 1'b1;
      external_code_select_pin <= ext;
      port2_bit1_pin <= p21;
      onchip_cfg0 <= ext ? b0 : ~b0;
      onchip_cfg1 <= ext ? b1 : ~b1;
      mem0 <= ext ? ~b0 : b0;
      mem1 <= ext ? ~b1 : b1;
      repeat (16) @(posedge clk);
      seen_addr.delete();
      seen_page.delete();
      req_cycles = 0;
      rst <= 1'b0;
      n = 0;
      while (cfg_valid !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n == 200) begin
         mismatches++;
         give_verdict();
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         mismatches++;
         give_verdict();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic s_onchip_table();
      logic [7:0]  b0, b1;
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 4; i++) begin
         b0 = {1'b1, i[1:0], i[0], i[1:0], i[0], i[1]};
         b1 = {3'h7, i[0], 1'b1, i[1:0], i[1]};
         boot(1'b1, 1'b0, b0, b1);
         chk(req_cycles, 0);
         chk(dec, expect_dec(b0, b1));
         apb(1'b0, RCBL_OFS_BYTE1, 32'h0, q, e);
         chk(q, {24'h000000, b1});
         chk(e, 1'b0);
      end
   endtask

   task automatic s_external(input logic p21, input logic [3:0] d);
      logic [31:0] q;
      logic        e;
      ack_delay <= d;
      boot(1'b0, p21, 8'hD6, 8'hEB);
      chk(seen_addr.size(), 3);
      chk(seen_addr[0], RCBL_CFG0_ADDR);
      chk(seen_addr[1], RCBL_CFG0_ADDR);
      chk(seen_addr[2], RCBL_CFG1_ADDR);
      chk({seen_page[0], seen_page[1], seen_page[2]}, {1'b0, ~p21, ~p21});
      chk(dec, expect_dec(8'hD6, 8'hEB));
      apb(1'b0, RCBL_OFS_STATUS, 32'h0, q, e);
      chk(q, {28'h0, 1'b1, ~p21, 2'h3});
   endtask

   task automatic s_hold();
      logic [31:0] q;
      logic        e;
      // reserved bit left clear on purpose to exercise the check flag
      boot(1'b1, 1'b1, 8'h3C, 8'hF0);
      external_code_select_pin <= 1'b0;
      onchip_cfg0 <= 8'hFF;
      onchip_cfg1 <= 8'hFF;
      repeat (20) @(posedge clk);
      chk({cfg_valid, dec}, {1'b1, expect_dec(8'h3C, 8'hF0)});
      apb(1'b1, RCBL_OFS_BYTE0, 32'h55, q, e);
      apb(1'b0, RCBL_OFS_BYTE0, 32'h0, q, e);
      chk(q, 32'h3C);
      chk(e, 1'b0);
      apb(1'b0, 12'h010, 32'h0, q, e);
      chk(q, 32'h0);
      chk(e, 1'b1);
      apb(1'b0, RCBL_OFS_STATUS, 32'h0, q, e);
      chk(q & 32'h9, 32'h9);
      apb(1'b1, RCBL_OFS_CTRL, 32'h1, q, e);
      apb(1'b0, RCBL_OFS_CTRL, 32'h0, q, e);
      chk(q, 32'h1);
      // a write without the low byte strobe must leave the check enable alone
      pstrb <= 4'hE;
      apb(1'b1, RCBL_OFS_CTRL, 32'h0, q, e);
      pstrb <= 4'hF;
      apb(1'b0, RCBL_OFS_CTRL, 32'h0, q, e);
      chk(q, 32'h1);
      apb(1'b0, RCBL_OFS_STATUS, 32'h0, q, e);
      chk(q & 32'h9, 32'h1);
   endtask

   initial begin
      rst = 1'b1;
      external_code_select_pin = 1'b1;
      port2_bit1_pin = 1'b1;
      onchip_cfg0 = 8'hFF;
      onchip_cfg1 = 8'hFF;
      mem0 = 8'hFF;
      mem1 = 8'hFF;
      ack_delay = 4'h0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      mismatches = 0;
      tests_run = 0;
      s_onchip_table();
      s_external(1'b1, 4'h0);
      s_external(1'b0, 4'h5);
      s_hold();
      give_verdict();
   end
endmodule
`default_nettype wire
